// File: design/hpa_ctrl.sv
// Slot A control pin logic: mode capture, latch transfer, LED, reset,
// I/O voltage and aux power outputs.
// Assumes pins are asynchronous to core_clk and the serial clock is
// a separate domain handled in hpa_shift.
`timescale 1ns/1ps
module hpa_ctrl
   import hpa_pkg::*;
#(
   parameter int CMD_W = `HPA_CMD_W,
   parameter int STAT_W = `HPA_STAT_W,
   parameter int BIT_PWR_EN = `HPA_BIT_PWR_EN,
   parameter int BIT_PWR_LED = `HPA_BIT_PWR_LED,
   parameter int BIT_ATT_LED = `HPA_BIT_ATT_LED,
   parameter int BIT_VIO_3V3 = `HPA_BIT_VIO_3V3
) (
   // Core clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Power state and straps
   input wire logic supplies_valid,
   input wire logic direct_mode_strap,
   // Serial link
   input wire logic slot_a_serial_clock,
   input wire logic slot_a_latch_clock,
   input wire logic serial_command_in,
   input wire logic serial_status_in,
   output logic serial_status_out,
   output logic serial_status_oe,
   output logic slot_chain_out,
   // Direct mode inputs
   input wire logic attention_led_enable_in,
   input wire logic power_led_enable_in,
   input wire logic io_voltage_select_in,
   // Reset control
   input wire logic slot_reset_control_in_n,
   output logic slot_reset_out_n,
   // Indicators, open drain
   input wire logic power_indicator_in,
   output logic power_indicator_out,
   output logic power_indicator_oe,
   output logic attention_indicator_out,
   output logic attention_indicator_oe,
   // Aux power
   input wire logic aux_power_switch_n,
   input wire logic aux_fault_detect,
   output logic aux_power_enable,
   output logic aux_fault_latch,
   // Slot control and status
   input wire logic [STAT_W-1:0] slot_status,
   output logic io_voltage_3v3,
   output logic slot_power_cmd,
   output logic forced_enable,
   output logic multi_slot_mode,
   output logic direct_mode
);
   // Refuse layouts the shift logic cannot carry
   generate
      if (CMD_W < 4 || STAT_W < 2) begin : g_bad_width
         $error("hpa_ctrl: shift widths too small");
      end
      if (BIT_PWR_EN >= CMD_W || BIT_PWR_LED >= CMD_W ||
          BIT_ATT_LED >= CMD_W || BIT_VIO_3V3 >= CMD_W) begin : g_bad_bit
         $error("hpa_ctrl: command bit outside shift word");
      end
   endgenerate

   hpa_state_t state_r;
   hpa_state_t state_nxt;
   hpa_mode_t mode_r;
   hpa_cmd_t cmd_r;
   logic [8:0] pins_s;
   logic sv_s;
   logic dir_s;
   logic multi_s;
   logic pwr_ind_s;
   logic latch_s;
   logic aled_s;
   logic pled_s;
   logic vio_s;
   logic rst_in_s;
   logic sw_on_s;
   logic fault_s;
   logic sv_d_r;
   logic latch_d_r;
   logic latch_pend_r;
   logic load_tgl_r;
   logic [CMD_W-1:0] cmd_shift;
   logic [CMD_W-1:0] word_s;
   logic [CMD_W-1:0] word_d_r;
   logic sv_rise;
   logic sv_fall;
   logic latch_rise;
   logic word_quiet;
   logic serial_r;
   logic status_bit;
   logic chain_bit;

   // Pull out the command fields from a latched word
   function automatic hpa_cmd_t decode_cmd(input logic [CMD_W-1:0] w);
      hpa_cmd_t c;
      c.pwr_en = w[BIT_PWR_EN];
      c.pwr_led = w[BIT_PWR_LED];
      c.att_led = w[BIT_ATT_LED];
      c.vio_3v3 = w[BIT_VIO_3V3];
      return c;
   endfunction : decode_cmd

   // All asynchronous pins through two flops
   hpa_sync #(.W(9)) u_pin_sync (
      .clk(core_clk),
      .rst_b(rst_b),
      .d({supplies_valid, direct_mode_strap, serial_status_in,
          power_indicator_in, slot_a_latch_clock, attention_led_enable_in,
          power_led_enable_in, io_voltage_select_in, slot_reset_control_in_n}),
      .q(pins_s)
   );
   assign {sv_s, dir_s, multi_s, pwr_ind_s, latch_s, aled_s, pled_s, vio_s,
           rst_in_s} = pins_s;

   // Aux switch inverted first, so the synchroniser's reset reads as off
   hpa_sync #(.W(2)) u_aux_sync (
      .clk(core_clk),
      .rst_b(rst_b),
      .d({~aux_power_switch_n, aux_fault_detect}),
      .q({sw_on_s, fault_s})
   );

   // Link-domain shift and status logic
   hpa_shift #(.CMD_W(CMD_W), .STAT_W(STAT_W)) u_shift (
      .slot_a_serial_clock(slot_a_serial_clock),
      .rst_b(rst_b),
      .serial_command_in(serial_command_in),
      .serial_status_bit(status_bit),
      .slot_chain_out(chain_bit),
      .serial_active(serial_r),
      .multi_slot(mode_r.multi),
      .status_load_tgl(load_tgl_r),
      .status_word(slot_status),
      .cmd_shift(cmd_shift)
   );

   // Shift word into core domain, plus one stage for a quiet check
   hpa_sync #(.W(CMD_W)) u_word_sync (
      .clk(core_clk),
      .rst_b(rst_b),
      .d(cmd_shift),
      .q(word_s)
   );

   // Edge detectors on synchronised levels
   assign sv_rise = sv_s & ~sv_d_r;
   assign sv_fall = ~sv_s & sv_d_r;
   assign latch_rise = latch_s & ~latch_d_r;
   assign word_quiet = (word_s == word_d_r);

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sv_d_r <= 1'b0;
         latch_d_r <= 1'b0;
         word_d_r <= '0;
      end else begin
         sv_d_r <= sv_s;
         latch_d_r <= latch_s;
         word_d_r <= word_s;
      end
   end

   // Mode state: off until supplies valid, then strap picks the mode
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         HPA_ST_OFF: begin
            if (sv_rise) begin
               state_nxt = dir_s ? HPA_ST_DIRECT : HPA_ST_SERIAL;
            end
         end
         HPA_ST_SERIAL, HPA_ST_DIRECT: begin
            if (sv_fall) begin
               state_nxt = HPA_ST_OFF;
            end
         end
         default: begin
            state_nxt = HPA_ST_OFF;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= HPA_ST_OFF;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Straps caught at supplies-valid rise
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_r <= '0;
      end else if (state_r == HPA_ST_OFF && sv_rise) begin
         mode_r.direct <= dir_s;
         mode_r.multi <= multi_s;
         mode_r.forced <= ~pwr_ind_s;
      end
   end

   // Serial activity level handed to the link domain
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         serial_r <= 1'b0;
      end else begin
         serial_r <= (state_nxt == HPA_ST_SERIAL);
      end
   end

   // Latch edge waits until the crossed shift word is quiet
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         latch_pend_r <= 1'b0;
      end else if (state_r != HPA_ST_SERIAL) begin
         latch_pend_r <= 1'b0;
      end else if (latch_rise) begin
         latch_pend_r <= ~word_quiet;
      end else if (word_quiet) begin
         latch_pend_r <= 1'b0;
      end
   end

   // Parallel command register, cleared when serial mode starts
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cmd_r <= '0;
      end else if (state_r == HPA_ST_OFF && state_nxt == HPA_ST_SERIAL) begin
         cmd_r <= '0;
      end else if (state_r == HPA_ST_SERIAL &&
                   (latch_rise || latch_pend_r) && word_quiet) begin
         cmd_r <= decode_cmd(word_s);
      end
   end

   // Status reload request after each transfer and at serial start
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         load_tgl_r <= 1'b0;
      end else if ((state_r == HPA_ST_OFF && state_nxt == HPA_ST_SERIAL) ||
                   (state_r == HPA_ST_SERIAL &&
                    (latch_rise || latch_pend_r) && word_quiet)) begin
         load_tgl_r <= ~load_tgl_r;
      end
   end

   // Status pin driven by the device only in serial mode
   assign serial_status_out = status_bit;
   assign slot_chain_out = chain_bit;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         serial_status_oe <= 1'b0;
      end else begin
         serial_status_oe <= (state_r == HPA_ST_SERIAL);
      end
   end

   // Aux fault latch: a new fault wins over a clear in the same cycle
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         aux_fault_latch <= 1'b0;
      end else if (fault_s) begin
         aux_fault_latch <= 1'b1;
      end else if (!sw_on_s) begin
         aux_fault_latch <= 1'b0;
      end
   end

   // Aux power follows the active-low switch input
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         aux_power_enable <= 1'b0;
      end else begin
         aux_power_enable <= sw_on_s;
      end
   end

   // Attention indicator: low while lit
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         attention_indicator_oe <= `HPA_RST_LED_ON;
      end else begin
         case (state_r)
            HPA_ST_OFF: attention_indicator_oe <= aux_fault_latch;
            HPA_ST_DIRECT: attention_indicator_oe <= aled_s;
            HPA_ST_SERIAL: attention_indicator_oe <= cmd_r.att_led;
            default: attention_indicator_oe <= 1'b0;
         endcase
      end
   end

   // Power indicator, released while supplies are invalid
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         power_indicator_oe <= `HPA_RST_LED_ON;
      end else begin
         case (state_r)
            HPA_ST_DIRECT: power_indicator_oe <= pled_s;
            HPA_ST_SERIAL: power_indicator_oe <= cmd_r.pwr_led;
            default: power_indicator_oe <= 1'b0;
         endcase
      end
   end

   // Open-drain pins only ever pull low
   assign attention_indicator_out = 1'b0;
   assign power_indicator_out = 1'b0;

   // Slot reset: serial mode follows the input, else held asserted
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         slot_reset_out_n <= `HPA_RST_RESET_N;
      end else if (state_r == HPA_ST_SERIAL) begin
         slot_reset_out_n <= rst_in_s;
      end else begin
         slot_reset_out_n <= `HPA_RST_RESET_N;
      end
   end

   // I/O voltage select: pin in direct mode, command in serial mode
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         io_voltage_3v3 <= `HPA_RST_VIO_3V3;
      end else begin
         case (state_r)
            HPA_ST_DIRECT: io_voltage_3v3 <= vio_s;
            HPA_ST_SERIAL: io_voltage_3v3 <= cmd_r.vio_3v3;
            default: io_voltage_3v3 <= `HPA_RST_VIO_3V3;
         endcase
      end
   end

   // Slot power request and mode flags
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         slot_power_cmd <= 1'b0;
         forced_enable <= 1'b0;
         multi_slot_mode <= 1'b0;
         direct_mode <= 1'b0;
      end else begin
         slot_power_cmd <= (state_r == HPA_ST_SERIAL) & cmd_r.pwr_en;
         forced_enable <= (state_r != HPA_ST_OFF) & mode_r.forced;
         multi_slot_mode <= (state_r == HPA_ST_SERIAL) & mode_r.multi;
         direct_mode <= (state_r == HPA_ST_DIRECT);
      end
   end
endmodule : hpa_ctrl

// File: design/hpa_map.svh
// Constants for the slot A control pin logic of the hot-plug controller.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef HPA_MAP_SVH
`define HPA_MAP_SVH

// Default shift register lengths
`define HPA_CMD_W 8
`define HPA_STAT_W 8

// Default command bit positions in the latched word
`define HPA_BIT_PWR_EN 0
`define HPA_BIT_PWR_LED 1
`define HPA_BIT_ATT_LED 2
`define HPA_BIT_VIO_3V3 3

// Reset values of the pin outputs
`define HPA_RST_RESET_N 1'b0
`define HPA_RST_LED_ON 1'b0
`define HPA_RST_VIO_3V3 1'b0

// Synchroniser depth
`define HPA_SYNC_STAGES 2

`endif

// File: design/hpa_pkg.sv
// Types shared by the slot A control pin logic.
// Assumes hpa_map.svh is on the include path.
package hpa_pkg;
`include "hpa_map.svh"

   // Decoded command fields, one bit each
   typedef struct packed {
      logic pwr_en;
      logic pwr_led;
      logic att_led;
      logic vio_3v3;
   } hpa_cmd_t;

   // Interface mode caught at supplies-valid rise
   typedef struct packed {
      logic direct;
      logic multi;
      logic forced;
   } hpa_mode_t;

   // Operating state, one-hot
   typedef enum logic [2:0] {
      HPA_ST_OFF = 3'b001,
      HPA_ST_SERIAL = 3'b010,
      HPA_ST_DIRECT = 3'b100
   } hpa_state_t;

endpackage : hpa_pkg

// File: design/hpa_sync.sv
// Multi-stage synchroniser for levels and quiet words.
// Assumes the source holds still long enough to be seen.
`timescale 1ns/1ps
module hpa_sync
   import hpa_pkg::*;
#(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   // First stage is read by the second stage only
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule : hpa_sync

// File: design/hpa_shift.sv
// Link side of the serial interface, on the slot A serial clock.
// Assumes the serial clock may stop between frames; core levels cross in.
`timescale 1ns/1ps
module hpa_shift
   import hpa_pkg::*;
#(
   parameter int CMD_W = `HPA_CMD_W,
   parameter int STAT_W = `HPA_STAT_W
) (
   // Link clock and reset
   input wire logic slot_a_serial_clock,
   input wire logic rst_b,
   // Link pins
   input wire logic serial_command_in,
   output logic serial_status_bit,
   output logic slot_chain_out,
   // From core domain
   input wire logic serial_active,
   input wire logic multi_slot,
   input wire logic status_load_tgl,
   input wire logic [STAT_W-1:0] status_word,
   // To core domain
   output logic [CMD_W-1:0] cmd_shift
);
   logic [2:0] ctl_s;
   logic [STAT_W-1:0] stat_s;
   logic load_seen_r;
   logic [STAT_W-1:0] stat_sh_r;

   // Core levels and the load toggle into the link domain
   hpa_sync #(.W(3)) u_ctl_sync (
      .clk(slot_a_serial_clock),
      .rst_b(rst_b),
      .d({serial_active, multi_slot, status_load_tgl}),
      .q(ctl_s)
   );
   hpa_sync #(.W(STAT_W)) u_stat_sync (
      .clk(slot_a_serial_clock),
      .rst_b(rst_b),
      .d(status_word),
      .q(stat_s)
   );

   // Command bits shift in, oldest toward the top
   // Shifts on every edge: the gated active level lags two edges of a stopped clock
   always_ff @(posedge slot_a_serial_clock or negedge rst_b) begin
      if (!rst_b) begin
         cmd_shift <= '0;
      end else begin
         cmd_shift <= {cmd_shift[CMD_W-2:0], serial_command_in};
      end
   end

   // Bit falling off the top goes to the next slot while serial is active in multi-slot mode, else the chain pin is held low
   always_ff @(posedge slot_a_serial_clock or negedge rst_b) begin
      if (!rst_b) begin
         slot_chain_out <= 1'b0;
      end else begin
         slot_chain_out <= ctl_s[2] & ctl_s[1] & cmd_shift[CMD_W-1];
      end
   end

   // Status reloads on a new toggle, otherwise shifts out
   always_ff @(posedge slot_a_serial_clock or negedge rst_b) begin
      if (!rst_b) begin
         load_seen_r <= 1'b0;
         stat_sh_r <= '0;
         serial_status_bit <= 1'b0;
      end else begin
         load_seen_r <= ctl_s[0];
         if (ctl_s[0] != load_seen_r) begin
            stat_sh_r <= stat_s;
            serial_status_bit <= stat_s[STAT_W-1];
         end else begin
            stat_sh_r <= {stat_sh_r[STAT_W-2:0], 1'b0};
            serial_status_bit <= stat_sh_r[STAT_W-2];
         end
      end
   end
endmodule : hpa_shift

// File: tb/hpa_properties.sv
// Checker for the slot A control pin logic, bound to every hpa_ctrl.
// Assumes pins are held steady for several core cycles around each change.
`timescale 1ns/1ps
module hpa_properties
   import hpa_pkg::*;
(
   // Core clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Straps, direct-mode, reset and aux inputs
   input wire logic supplies_valid,
   input wire logic direct_mode_strap,
   input wire logic serial_status_in,
   input wire logic power_indicator_in,
   input wire logic attention_led_enable_in,
   input wire logic power_led_enable_in,
   input wire logic io_voltage_select_in,
   input wire logic slot_reset_control_in_n,
   input wire logic aux_power_switch_n,
   input wire logic aux_fault_detect,
   // Watched outputs
   input wire logic serial_status_oe,
   input wire logic slot_reset_out_n,
   input wire logic power_indicator_oe,
   input wire logic attention_indicator_oe,
   input wire logic aux_power_enable,
   input wire logic aux_fault_latch,
   input wire logic io_voltage_3v3,
   input wire logic forced_enable,
   input wire logic multi_slot_mode,
   input wire logic direct_mode
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   // Aux power switch and fault latch
   a_aux_enable_on: assert property ((!aux_power_switch_n)[*4] |-> aux_power_enable)
      else $error("aux power not enabled by switch");
   a_fault_clears: assert property ((aux_power_switch_n && !aux_fault_detect)[*4] |->
      !aux_fault_latch) else $error("aux fault latch not cleared");
   a_off_att_fault: assert property ((!supplies_valid)[*6] ##1
      (!supplies_valid && $stable(aux_fault_latch)) |-> attention_indicator_oe == aux_fault_latch)
      else $error("attention pin does not show aux fault");
   // Direct mode pin following
   a_direct_att_led: assert property ((supplies_valid && direct_mode &&
      $stable(attention_led_enable_in))[*5] |-> attention_indicator_oe == attention_led_enable_in)
      else $error("attention pin does not follow enable");
   a_direct_pwr_led: assert property ((supplies_valid && direct_mode &&
      $stable(power_led_enable_in))[*5] |-> power_indicator_oe == power_led_enable_in)
      else $error("power pin does not follow enable");
   a_direct_vio_sel: assert property ((supplies_valid && direct_mode &&
      $stable(io_voltage_select_in))[*5] |-> io_voltage_3v3 == io_voltage_select_in)
      else $error("io voltage does not follow select");
   a_direct_no_reset: assert property (direct_mode |-> !slot_reset_out_n)
      else $error("slot reset released in direct mode");
   // Serial mode reset and defaults
   a_serial_reset: assert property ((serial_status_oe && $stable(slot_reset_control_in_n))[*5]
      |-> slot_reset_out_n == slot_reset_control_in_n) else $error("slot reset not following");
   a_serial_entry: assert property ($rose(serial_status_oe) |->
      !power_indicator_oe && !attention_indicator_oe) else $error("indicator lit at serial start");
   // Straps caught at supplies-valid rise
   a_mode_capture: assert property ($rose(supplies_valid) ##1 (supplies_valid &&
      $stable(direct_mode_strap) && $stable(power_indicator_in))[*6] |->
      direct_mode == direct_mode_strap && serial_status_oe == !direct_mode_strap &&
      forced_enable == !power_indicator_in) else $error("mode straps not captured");
   a_slot_count: assert property (($rose(supplies_valid) && !direct_mode_strap) ##1
      supplies_valid[*6] |-> multi_slot_mode == $past(serial_status_in, 7))
      else $error("slot count strap not captured");
endmodule : hpa_properties

bind hpa_ctrl hpa_properties i_props (.core_clk, .rst_b, .supplies_valid, .direct_mode_strap,
   .serial_status_in, .power_indicator_in, .attention_led_enable_in, .power_led_enable_in,
   .io_voltage_select_in, .slot_reset_control_in_n, .aux_power_switch_n, .aux_fault_detect,
   .serial_status_oe, .slot_reset_out_n, .power_indicator_oe, .attention_indicator_oe,
   .aux_power_enable, .aux_fault_latch, .io_voltage_3v3, .forced_enable, .multi_slot_mode,
   .direct_mode);

// File: tb/hpa_link_ctrl.sv
// Controller side of the slot A serial link: clock, command bits, latch.
// Assumes the bench calls frame() and supplies a free-running bus clock.
`timescale 1ns/1ps
module hpa_link_ctrl
   import hpa_pkg::*;
(
   // Bus segment clock
   input wire logic pci_clk,
   // Link pins
   output logic slot_a_serial_clock,
   output logic serial_command_in,
   output logic slot_a_latch_clock,
   input wire logic status_pin,
   input wire logic chain_pin
);
   // Pins at rest, clock still between frames
   initial begin
      slot_a_serial_clock = 1'b0;
      serial_command_in = 1'b0;
      slot_a_latch_clock = 1'b0;
   end

   // Shift 16 bits MSB first at 160 ns, sample status and chain, then latch
   task automatic frame(input logic [15:0] bits, output logic [15:0] stat,
         output logic [15:0] chain);
      #1.3;
      for (int i = 15; i >= 0; i--) begin
         serial_command_in = bits[i];
         #80 slot_a_serial_clock = 1'b1;
         #40 stat[i] = status_pin;
         chain[i] = chain_pin;
         #40 slot_a_serial_clock = 1'b0;
      end
      serial_command_in = ~serial_command_in; // Stale level is not kept
      repeat (8) @(posedge pci_clk);
      slot_a_latch_clock <= 1'b1;
      repeat (8) @(posedge pci_clk);
      slot_a_latch_clock <= 1'b0;
      repeat (8) @(posedge pci_clk);
   endtask : frame
endmodule : hpa_link_ctrl

// File: tb/hpa_ctrl_tb_top.sv
// Self-checking bench for the slot A control pin logic.
// Assumes the link controller model and the bound checker are compiled first.
`timescale 1ns/1ps
module hpa_ctrl_tb_top
   import hpa_pkg::*;
;
   // Pins and bookkeeping
   logic core_clk, rst_b, supplies_valid, direct_mode_strap, stat_pull, pled_pull;
   logic att_en, pled_en, vio_sel, rst_ctl_n, sw_n, fault, sclk, latch, cmd_bit;
   logic stat_out, stat_oe, chain, att_oe, pwr_oe, aux_en, aux_flt, rst_out_n;
   logic vio_3v3, pwr_cmd, forced, multi, direct, stat_pin, pled_pin;
   logic [7:0] slot_status;
   int error_cnt, total_checks, cyc;

   // Open-drain and strapped pin levels
   assign stat_pin = stat_oe ? stat_out : stat_pull;
   assign pled_pin = pwr_oe ? 1'b0 : pled_pull;

   hpa_ctrl i_dut (.core_clk(core_clk), .rst_b(rst_b), .supplies_valid(supplies_valid),
      .direct_mode_strap(direct_mode_strap), .slot_a_serial_clock(sclk),
      .slot_a_latch_clock(latch), .serial_command_in(cmd_bit), .serial_status_in(stat_pin),
      .serial_status_out(stat_out), .serial_status_oe(stat_oe), .slot_chain_out(chain),
      .attention_led_enable_in(att_en), .power_led_enable_in(pled_en),
      .io_voltage_select_in(vio_sel), .slot_reset_control_in_n(rst_ctl_n),
      .slot_reset_out_n(rst_out_n), .power_indicator_in(pled_pin), .power_indicator_out(),
      .power_indicator_oe(pwr_oe), .attention_indicator_out(), .attention_indicator_oe(att_oe),
      .aux_power_switch_n(sw_n), .aux_fault_detect(fault), .aux_power_enable(aux_en),
      .aux_fault_latch(aux_flt), .slot_status(slot_status), .io_voltage_3v3(vio_3v3),
      .slot_power_cmd(pwr_cmd), .forced_enable(forced), .multi_slot_mode(multi),
      .direct_mode(direct));

   hpa_link_ctrl i_link (.pci_clk(core_clk), .slot_a_serial_clock(sclk),
      .serial_command_in(cmd_bit), .slot_a_latch_clock(latch), .status_pin(stat_pin),
      .chain_pin(chain));

   // Core clock, 200 MHz
   always #2.5 core_clk = ~core_clk;

   // Cycle ceiling against hangs
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         error_cnt++;
         results();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tick

   // One-bit compare with count
   task automatic chk1(input logic got, input logic exp, input string what);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask : chk1

   // True if the byte appears MSB first anywhere in the stream
   function automatic logic has_seq(input logic [15:0] s, input logic [7:0] p);
      has_seq = 1'b0;
      for (int k = 0; k <= 8; k++) begin
         if (s[k +: 8] === p) begin
            has_seq = 1'b1;
         end
      end
   endfunction : has_seq

   // Supplies drop and rise with the given straps
   task automatic pwr_up(input logic dstrap, input logic spull, input logic ppull);
      supplies_valid <= 1'b0;
      att_en <= 1'b0;
      pled_en <= 1'b0;
      tick(8);
      direct_mode_strap <= dstrap;
      stat_pull <= spull;
      pled_pull <= ppull;
      tick(4);
      supplies_valid <= 1'b1;
      tick(8);
      chk1(direct, dstrap, "direct flag");
      chk1(stat_oe, !dstrap, "status pin drive");
      chk1(forced, !ppull, "forced enable");
      chk1(multi, spull & !dstrap, "multi-slot flag");
      chk1(pwr_oe | att_oe, 1'b0, "indicators at start");
   endtask : pwr_up

   // Aux switch, fault latch and attention pin with supplies off
   task automatic t_aux;
      supplies_valid <= 1'b0;
      sw_n <= 1'b0;
      tick(8);
      chk1(aux_en, 1'b1, "aux enable");
      chk1(att_oe, 1'b0, "attention idle");
      fault <= 1'b1;
      tick(8);
      fault <= 1'b0;
      tick(8);
      chk1(aux_flt, 1'b1, "fault latched");
      chk1(att_oe, 1'b1, "attention shows fault");
      sw_n <= 1'b1;
      tick(8);
      chk1(aux_flt, 1'b0, "fault cleared");
      chk1(aux_en, 1'b0, "aux disable");
      chk1(att_oe, 1'b0, "attention cleared");
   endtask : t_aux

   // Direct mode: enables, reset input ignored, voltage select
   task automatic t_direct;
      logic [1:0] v;
      pwr_up(1'b1, 1'b0, 1'b0);
      for (int i = 0; i < 4; i++) begin
         v = i[1:0];
         att_en <= v[0];
         pled_en <= v[1];
         rst_ctl_n <= v[0];
         tick(8);
         chk1(att_oe, v[0], "attention follows enable");
         chk1(pwr_oe, v[1], "power LED follows enable");
         chk1(rst_out_n, 1'b0, "reset input ignored");
      end
      for (int i = 0; i < 2; i++) begin
         vio_sel <= i[0];
         tick(8);
         chk1(vio_3v3, i[0], "io voltage select");
      end
   endtask : t_direct

   // Serial mode: two frames, latch, chain, status and reset control
   task automatic t_serial(input logic spull);
      logic [15:0] st, ch;
      pwr_up(1'b0, spull, 1'b1);
      i_link.frame(16'h5A0F, st, ch);
      tick(4);
      chk1(pwr_cmd, 1'b1, "power command");
      chk1(pwr_oe, 1'b1, "power LED command");
      chk1(att_oe, 1'b1, "attention command");
      chk1(vio_3v3, 1'b1, "io voltage command");
      i_link.frame(16'h3C02, st, ch);
      tick(4);
      chk1(pwr_cmd | att_oe | vio_3v3, 1'b0, "commands cleared");
      chk1(pwr_oe, 1'b1, "power LED kept");
      chk1(has_seq(ch, 8'h3C), spull, "chain forwarding");
      chk1(|ch, spull, "chain idle in single mode");
      chk1(has_seq(st, slot_status), 1'b1, "status stream");
      for (int i = 0; i < 2; i++) begin
         rst_ctl_n <= i[0];
         tick(8);
         chk1(rst_out_n, i[0], "reset follows input");
      end
   endtask : t_serial

   // Counts and verdict
   task automatic results;
      $display("checks %0d, mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : results

   // Main sequence
   initial begin
      core_clk = 1'b0;
      rst_b = 1'b0;
      {supplies_valid, direct_mode_strap, stat_pull, att_en, pled_en, vio_sel, fault} = '0;
      {pled_pull, rst_ctl_n, sw_n} = 3'h7;
      slot_status = 8'hA5;
      error_cnt = 0;
      total_checks = 0;
      cyc = 0;
      tick(4);
      rst_b <= 1'b1;
      tick(4);
      t_aux();
      t_direct();
      t_serial(1'b1);
      t_serial(1'b0);
      results();
   end
endmodule : hpa_ctrl_tb_top
